/* design/gpiof_pkg.sv */
// Constants for the two-port GPIO block: offsets, fields, resets, times.
// Assumes the peripheral clock equals core_clk (250 MHz).
package gpiof_pkg;

  // Register offsets
  localparam logic [15:0] PORT2_FILTER_SELECT_OFS = 16'h5228;
  localparam logic [15:0] PORT2_INPUT_ENABLE_OFS  = 16'h522A;
  localparam logic [15:0] PORT3_PIN_LEVELS_OFS   = 16'h5230;
  localparam logic [15:0] PORT3_OUTPUT_DATA_OFS  = 16'h5231;
  localparam logic [15:0] PORT3_DRIVE_ENABLE_OFS  = 16'h5232;
  localparam logic [15:0] PORT3_PULLUP_ENABLE_OFS   = 16'h5233;
  localparam logic [15:0] PORT3_HYSTERESIS_SELECT_OFS   = 16'h5234;
  localparam logic [15:0] PORT3_IRQ_MASK_OFS = 16'h5235;
  localparam logic [15:0] PORT3_IRQ_POLARITY_OFS = 16'h5236;
  localparam logic [15:0] PORT3_IRQ_PENDING_OFS = 16'h5237;
  localparam logic [15:0] PORT3_FILTER_SELECT_OFS = 16'h5238;
  localparam logic [15:0] PORT3_INPUT_ENABLE_OFS  = 16'h523A;

  // Field positions
  localparam int LO_CODE_LSB = 0;
  localparam int HI_CODE_LSB = 4;
  localparam int OEN_ONE_BIT = 5;

  // Reset values
  localparam logic [2:0] CODE_RST   = 3'h0;
  localparam logic [7:0] PORT2_INPUT_ENABLE_RST = 8'hFF;
  localparam logic [4:0] PORT3_OUTPUT_DATA_RST = 5'h00;
  localparam logic [4:0] PORT3_DRIVE_ENABLE_RST = 5'h00;
  localparam logic [4:0] PORT3_PULLUP_ENABLE_RST  = 5'h1F;
  localparam logic [4:0] PORT3_HYSTERESIS_SELECT_RST  = 5'h1F;
  localparam logic [4:0] P3_IE_RST  = 5'h00;
  localparam logic [4:0] P3_EDG_RST = 5'h00;
  localparam logic [4:0] P3_IF_RST  = 5'h00;
  localparam logic [4:0] PORT3_INPUT_ENABLE_RST = 5'h1F;

  // Clock periods in ns
  localparam int CLK_NS   = 4;
  localparam int FPCLK_NS = 4;

  // Filter times in peripheral clock periods, per code
  localparam int FLT_T1 = 256;
  localparam int FLT_T2 = 512;
  localparam int FLT_T3 = 1024;
  localparam int FLT_T4 = 2048;
  localparam int FLT_T5 = 4096;
  localparam int FLT_T6 = 8192;
  localparam int FLT_T7 = 6384;

  // Filter times in core_clk cycles, rounded up
  localparam logic [13:0] FLT_CNT_1 =
    14'((FLT_T1 * FPCLK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] FLT_CNT_2 =
    14'((FLT_T2 * FPCLK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] FLT_CNT_3 =
    14'((FLT_T3 * FPCLK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] FLT_CNT_4 =
    14'((FLT_T4 * FPCLK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] FLT_CNT_5 =
    14'((FLT_T5 * FPCLK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] FLT_CNT_6 =
    14'((FLT_T6 * FPCLK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] FLT_CNT_7 =
    14'((FLT_T7 * FPCLK_NS + CLK_NS - 1) / CLK_NS);

  // Cycles after reset before edges may raise flags
  localparam logic [2:0] ARM_CYC = 3'h4;

endpackage : gpiof_pkg

/* design/gpiof_top.sv */
// Port 2 filter/input-gate tail and full port 3 GPIO logic.
// Assumes pins are asynchronous; software on a one-cycle strobe bus.
// Function
// - Port2 upper pins filter code, 256..8192,6384.
// - Port2 lower pins filter code, same mapping.
// - Port2 input enable per pin, resets all on.
// - Port3 level bits read synchronised, filtered, input-gated pin state.
// - Port3 output enable drives output data bit.
// - Port3 pull-up enable bits reset set.
// - Port3 Schmitt select bits reset set.
// - Only enabled pins forward flag as interrupt.
// - Edge select: one falling, zero rising.
// - Edge sets flag; write one clears.
// - Port3 upper filter code covers pin four.
// - Port3 lower filter code covers pins 0-3.
// - Port3 input enable per pin, resets on.
`timescale 1ns/1ns
module gpiof_top #(
  parameter logic [13:0] FLT_C1 = gpiof_pkg::FLT_CNT_1,
  parameter logic [13:0] FLT_C2 = gpiof_pkg::FLT_CNT_2,
  parameter logic [13:0] FLT_C3 = gpiof_pkg::FLT_CNT_3,
  parameter logic [13:0] FLT_C4 = gpiof_pkg::FLT_CNT_4,
  parameter logic [13:0] FLT_C5 = gpiof_pkg::FLT_CNT_5,
  parameter logic [13:0] FLT_C6 = gpiof_pkg::FLT_CNT_6,
  parameter logic [13:0] FLT_C7 = gpiof_pkg::FLT_CNT_7
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Port 2 pins
  input  wire logic [7:0]  p2_pin_in,
  output logic      [7:0]  p2_level,
  output logic      [7:0]  port2_input_gate_bits,
  // Port 3 pins
  input  wire logic [4:0]  p3_pin_in,
  output logic      [4:0]  p3_pin_out,
  output logic      [4:0]  p3_pin_oe_n,
  output logic      [4:0]  port3_pullup_bits,
  output logic      [4:0]  port3_hysteresis_bits,
  // Interrupt
  output logic             irq
);

  localparam int NPIN = 13;

  // Configuration registers
  logic [2:0]  p2_hi_reg, p2_hi_next;
  logic [2:0]  p2_lo_reg, p2_lo_next;
  logic [7:0]  port2_input_enable_reg, port2_input_enable_next;
  logic [4:0]  port3_output_data_reg, port3_output_data_next;
  logic [4:0]  port3_drive_enable_reg, port3_drive_enable_next;
  logic [4:0]  port3_pullup_enable_reg, port3_pullup_enable_next;
  logic [4:0]  port3_hysteresis_select_reg, port3_hysteresis_select_next;
  logic [4:0]  p3_ie_reg, p3_ie_next;
  logic [4:0]  p3_pol_reg, p3_pol_next;
  logic [2:0]  p3_hi_reg, p3_hi_next;
  logic [2:0]  p3_lo_reg, p3_lo_next;
  logic [4:0]  port3_input_enable_reg, port3_input_enable_next;
  // Interrupt state
  logic [4:0]  p3_pend_reg, p3_pend_next;
  logic [4:0]  p3_prev_reg, p3_prev_next;
  logic [2:0]  arm_reg, arm_next;
  logic [4:0]  p3_evt;
  logic [4:0]  p3_lvl;
  logic [4:0]  w1c_bits;
  // Pin input path
  logic [12:0] sync1_reg, sync2_reg;
  logic [12:0] flt_raw;
  logic [12:0] flt_stable_reg;
  logic [13:0] flt_cnt_reg [NPIN];
  logic [2:0]  pin_code [NPIN];
  // Read port
  logic [7:0]  rdata_next;

  function automatic logic wr_at(input logic [15:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction : wr_at

  function automatic logic [13:0] flt_limit(input logic [2:0] code);
    logic [13:0] lim;
    case (code)
      3'h1:    lim = FLT_C1;
      3'h2:    lim = FLT_C2;
      3'h3:    lim = FLT_C3;
      3'h4:    lim = FLT_C4;
      3'h5:    lim = FLT_C5;
      3'h6:    lim = FLT_C6;
      3'h7:    lim = FLT_C7;
      default: lim = 14'h0001;
    endcase
    return lim;
  endfunction : flt_limit

  // Software-written configuration
  always_comb begin
    p2_hi_next  = p2_hi_reg;
    p2_lo_next  = p2_lo_reg;
    port2_input_enable_next = port2_input_enable_reg;
    port3_output_data_next = port3_output_data_reg;
    port3_drive_enable_next = port3_drive_enable_reg;
    port3_pullup_enable_next  = port3_pullup_enable_reg;
    port3_hysteresis_select_next  = port3_hysteresis_select_reg;
    p3_ie_next  = p3_ie_reg;
    p3_pol_next = p3_pol_reg;
    p3_hi_next  = p3_hi_reg;
    p3_lo_next  = p3_lo_reg;
    port3_input_enable_next = port3_input_enable_reg;
    if (wr_at(gpiof_pkg::PORT2_FILTER_SELECT_OFS)) begin
      p2_hi_next = reg_wdata[gpiof_pkg::HI_CODE_LSB +: 3];
      p2_lo_next = reg_wdata[gpiof_pkg::LO_CODE_LSB +: 3];
    end
    if (wr_at(gpiof_pkg::PORT2_INPUT_ENABLE_OFS))
      port2_input_enable_next = reg_wdata;
    if (wr_at(gpiof_pkg::PORT3_OUTPUT_DATA_OFS))
      port3_output_data_next = reg_wdata[4:0];
    if (wr_at(gpiof_pkg::PORT3_DRIVE_ENABLE_OFS))
      port3_drive_enable_next = reg_wdata[4:0];
    if (wr_at(gpiof_pkg::PORT3_PULLUP_ENABLE_OFS))
      port3_pullup_enable_next = reg_wdata[4:0];
    if (wr_at(gpiof_pkg::PORT3_HYSTERESIS_SELECT_OFS))
      port3_hysteresis_select_next = reg_wdata[4:0];
    if (wr_at(gpiof_pkg::PORT3_IRQ_MASK_OFS))
      p3_ie_next = reg_wdata[4:0];
    if (wr_at(gpiof_pkg::PORT3_IRQ_POLARITY_OFS))
      p3_pol_next = reg_wdata[4:0];
    if (wr_at(gpiof_pkg::PORT3_FILTER_SELECT_OFS)) begin
      p3_hi_next = reg_wdata[gpiof_pkg::HI_CODE_LSB +: 3];
      p3_lo_next = reg_wdata[gpiof_pkg::LO_CODE_LSB +: 3];
    end
    if (wr_at(gpiof_pkg::PORT3_INPUT_ENABLE_OFS))
      port3_input_enable_next = reg_wdata[4:0];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      p2_hi_reg  <= gpiof_pkg::CODE_RST;
      p2_lo_reg  <= gpiof_pkg::CODE_RST;
      port2_input_enable_reg <= gpiof_pkg::PORT2_INPUT_ENABLE_RST;
      port3_output_data_reg <= gpiof_pkg::PORT3_OUTPUT_DATA_RST;
      port3_drive_enable_reg <= gpiof_pkg::PORT3_DRIVE_ENABLE_RST;
      port3_pullup_enable_reg  <= gpiof_pkg::PORT3_PULLUP_ENABLE_RST;
      port3_hysteresis_select_reg  <= gpiof_pkg::PORT3_HYSTERESIS_SELECT_RST;
      p3_ie_reg  <= gpiof_pkg::P3_IE_RST;
      p3_pol_reg <= gpiof_pkg::P3_EDG_RST;
      p3_hi_reg  <= gpiof_pkg::CODE_RST;
      p3_lo_reg  <= gpiof_pkg::CODE_RST;
      port3_input_enable_reg <= gpiof_pkg::PORT3_INPUT_ENABLE_RST;
    end else begin
      p2_hi_reg  <= p2_hi_next;
      p2_lo_reg  <= p2_lo_next;
      port2_input_enable_reg <= port2_input_enable_next;
      port3_output_data_reg <= port3_output_data_next;
      port3_drive_enable_reg <= port3_drive_enable_next;
      port3_pullup_enable_reg  <= port3_pullup_enable_next;
      port3_hysteresis_select_reg  <= port3_hysteresis_select_next;
      p3_ie_reg  <= p3_ie_next;
      p3_pol_reg <= p3_pol_next;
      p3_hi_reg  <= p3_hi_next;
      p3_lo_reg  <= p3_lo_next;
      port3_input_enable_reg <= port3_input_enable_next;
    end
  end

  // Pad controls
  assign p3_pin_out            = port3_output_data_reg;
  assign p3_pin_oe_n           = ~port3_drive_enable_reg;
  assign port3_pullup_bits     = port3_pullup_enable_reg;
  assign port3_hysteresis_bits = port3_hysteresis_select_reg;
  assign port2_input_gate_bits = port2_input_enable_reg;

  // Pin synchronisers, bits 7:0 port 2, 12:8 port 3
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync1_reg <= 13'h0000;
      sync2_reg <= 13'h0000;
    end else begin
      sync1_reg <= {p3_pin_in, p2_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Disabled inputs read low
  assign flt_raw = sync2_reg & {port3_input_enable_reg, port2_input_enable_reg};

  // Filter code per pin
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (i < 4)
        pin_code[i] = p2_lo_reg;
      else if (i < 8)
        pin_code[i] = p2_hi_reg;
      else if (i < 12)
        pin_code[i] = p3_lo_reg;
      else
        pin_code[i] = p3_hi_reg;
    end
  end

  // Chattering filters
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_flt
      logic [13:0] cnt_next;
      logic        stb_next;
      always_comb begin
        cnt_next = 14'h0000;
        stb_next = flt_stable_reg[g];
        if (pin_code[g] == 3'h0) begin
          stb_next = flt_raw[g];
        end else if (flt_raw[g] != flt_stable_reg[g]) begin
          if (flt_cnt_reg[g] >=
              flt_limit(pin_code[g]) - 14'h0001) begin
            stb_next = flt_raw[g];
          end else begin
            cnt_next = flt_cnt_reg[g] + 14'h0001;
          end
        end
      end
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          flt_cnt_reg[g]    <= 14'h0000;
          flt_stable_reg[g] <= 1'b0;
        end else begin
          flt_cnt_reg[g]    <= cnt_next;
          flt_stable_reg[g] <= stb_next;
        end
      end
    end
  endgenerate

  assign p2_level = flt_stable_reg[7:0];
  assign p3_lvl   = flt_stable_reg[12:8];

  // Edge detection and flags
  always_comb begin
    arm_next = arm_reg;
    if (arm_reg != gpiof_pkg::ARM_CYC)
      arm_next = arm_reg + 3'h1;
    p3_prev_next = p3_lvl;
    p3_evt = 5'h00;
    if (arm_reg == gpiof_pkg::ARM_CYC)
      p3_evt = (p3_pol_reg & p3_prev_reg & ~p3_lvl) |
               (~p3_pol_reg & ~p3_prev_reg & p3_lvl);
    w1c_bits = 5'h00;
    if (wr_at(gpiof_pkg::PORT3_IRQ_PENDING_OFS))
      w1c_bits = reg_wdata[4:0];
    // Set wins over a clear in the same cycle
    p3_pend_next = (p3_pend_reg & ~w1c_bits) | p3_evt;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      arm_reg     <= 3'h0;
      p3_prev_reg <= 5'h00;
      p3_pend_reg <= gpiof_pkg::P3_IF_RST;
    end else begin
      arm_reg     <= arm_next;
      p3_prev_reg <= p3_prev_next;
      p3_pend_reg <= p3_pend_next;
    end
  end

  assign irq = |(p3_pend_reg & p3_ie_reg);

  // Read data, valid only the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (!reg_rd)
      rdata_next = 8'h00;
    else if (reg_addr == gpiof_pkg::PORT2_FILTER_SELECT_OFS)
      rdata_next = {1'b0, p2_hi_reg, 1'b0, p2_lo_reg};
    else if (reg_addr == gpiof_pkg::PORT2_INPUT_ENABLE_OFS)
      rdata_next = port2_input_enable_reg;
    else if (reg_addr == gpiof_pkg::PORT3_PIN_LEVELS_OFS)
      rdata_next = {3'h0, p3_lvl};
    else if (reg_addr == gpiof_pkg::PORT3_OUTPUT_DATA_OFS)
      rdata_next = {3'h0, port3_output_data_reg};
    else if (reg_addr == gpiof_pkg::PORT3_DRIVE_ENABLE_OFS)
      rdata_next = {2'h0, 1'b1, port3_drive_enable_reg};
    else if (reg_addr == gpiof_pkg::PORT3_PULLUP_ENABLE_OFS)
      rdata_next = {3'h0, port3_pullup_enable_reg};
    else if (reg_addr == gpiof_pkg::PORT3_HYSTERESIS_SELECT_OFS)
      rdata_next = {3'h0, port3_hysteresis_select_reg};
    else if (reg_addr == gpiof_pkg::PORT3_IRQ_MASK_OFS)
      rdata_next = {3'h0, p3_ie_reg};
    else if (reg_addr == gpiof_pkg::PORT3_IRQ_POLARITY_OFS)
      rdata_next = {3'h0, p3_pol_reg};
    else if (reg_addr == gpiof_pkg::PORT3_IRQ_PENDING_OFS)
      rdata_next = {3'h0, p3_pend_reg};
    else if (reg_addr == gpiof_pkg::PORT3_FILTER_SELECT_OFS)
      rdata_next = {1'b0, p3_hi_reg, 1'b0, p3_lo_reg};
    else if (reg_addr == gpiof_pkg::PORT3_INPUT_ENABLE_OFS)
      rdata_next = {3'h0, port3_input_enable_reg};
  end

  always_ff @(posedge core_clk) begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_next;
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_at(logic [15:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  sequence s_wr_at(logic [15:0] ofs);
    reg_wr && reg_addr == ofs;
  endsequence

  p2_hi_hold_a: assert property (
    $changed(flt_stable_reg[4]) && $past(p2_hi_reg) != 3'h0
    |-> $past(flt_cnt_reg[4]) + 14'h0001 ==
        flt_limit($past(p2_hi_reg)))
    else $error("port2 high filter accepted early");

  p2_lo_pass_a: assert property (
    p2_lo_reg == 3'h0 && $past(p2_lo_reg) == 3'h0
    |-> flt_stable_reg[0] == $past(flt_raw[0]))
    else $error("port2 low unfiltered pin lagged");

  port2_input_enable_rst_a: assert property (
    $rose(rstn) |-> port2_input_enable_reg == gpiof_pkg::PORT2_INPUT_ENABLE_RST
      && port3_input_enable_reg == gpiof_pkg::PORT3_INPUT_ENABLE_RST)
    else $error("input enables not set after reset");

  p3_lvl_rd_a: assert property (
    s_rd_at(gpiof_pkg::PORT3_PIN_LEVELS_OFS)
    |=> reg_rdata == {3'h0, $past(p3_lvl)})
    else $error("level read mismatch");

  p3_drive_a: assert property (
    s_wr_at(gpiof_pkg::PORT3_OUTPUT_DATA_OFS) ##1 !reg_wr
    |-> p3_pin_out == $past(reg_wdata[4:0], 1)
      || p3_pin_out == $past(reg_wdata[4:0], 2))
    else $error("output data not driven");

  p3_pad_rst_a: assert property (
    $rose(rstn) |-> port3_pullup_bits == gpiof_pkg::PORT3_PULLUP_ENABLE_RST
      && port3_hysteresis_bits == gpiof_pkg::PORT3_HYSTERESIS_SELECT_RST
      && p3_pin_oe_n == ~gpiof_pkg::PORT3_DRIVE_ENABLE_RST)
    else $error("pad controls wrong after reset");

  irq_gate_a: assert property (
    (p3_pend_reg & p3_ie_reg) == 5'h00 |-> !irq)
    else $error("masked flag raised interrupt");

  edge_set_a: assert property (
    arm_reg == gpiof_pkg::ARM_CYC && !p3_pol_reg[0]
      && !p3_prev_reg[0] && p3_lvl[0] |=> p3_pend_reg[0])
    else $error("rising edge did not set flag");

  flag_w1c_a: assert property (
    s_wr_at(gpiof_pkg::PORT3_IRQ_PENDING_OFS) && p3_evt == 5'h00
    |=> (p3_pend_reg & $past(w1c_bits)) == 5'h00)
    else $error("write one did not clear flag");

  p3_hi_hold_a: assert property (
    $changed(flt_stable_reg[12]) && $past(p3_hi_reg) != 3'h0
    |-> $past(flt_cnt_reg[12]) + 14'h0001 ==
        flt_limit($past(p3_hi_reg)))
    else $error("pin four filter accepted early");

  p3_lo_hold_a: assert property (
    $changed(flt_stable_reg[8]) && $past(p3_lo_reg) != 3'h0
    |-> $past(flt_cnt_reg[8]) + 14'h0001 ==
        flt_limit($past(p3_lo_reg)))
    else $error("port3 low filter accepted early");

  p3_gate_a: assert property (
    !$past(port3_input_enable_reg[0]) && $past(p3_lo_reg) == 3'h0 |-> !p3_lvl[0])
    else $error("disabled input leaked");

  oen_rd_a: assert property (
    s_rd_at(gpiof_pkg::PORT3_DRIVE_ENABLE_OFS) |=> reg_rdata[7:5] == 3'h1)
    else $error("reserved enable bits wrong");

endmodule : gpiof_top

/* bench/gpiof_pins.sv */
// Board model for the five port 3 pins: device driver, pull-ups, switches.
// Assumes a switch can only pull a pin low; a pin nobody holds floats.
`timescale 1ns/1ns
module gpiof_pins (
  // Clock
  input  wire logic       core_clk,
  // Device side
  input  wire logic [4:0] drv_val,
  input  wire logic [4:0] drv_oe_n,
  input  wire logic [4:0] pull_en,
  // Board side
  input  wire logic [4:0] ext_val,
  input  wire logic [4:0] ext_en,
  output logic      [4:0] pin
);
  logic [4:0] float_q = 5'h15;

  // Floating pins wander every cycle
  always @(posedge core_clk) float_q <= ~float_q;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!drv_oe_n[i]) pin[i] = drv_val[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pull_en[i]) pin[i] = 1'b1;
      else pin[i] = float_q[i];
    end
  end
endmodule : gpiof_pins

/* bench/tb.sv */
// Self-checking bench for the GPIO block: registers, pins, edges, filters.
// Assumes short filter counts and the board model on port 3.
`timescale 1ns/1ns
module tb;
  localparam int LIM [1:7] = '{4, 6, 8, 10, 12, 14, 11};
  localparam logic [15:0] AD [13] = '{gpiof_pkg::PORT2_FILTER_SELECT_OFS,
    gpiof_pkg::PORT2_INPUT_ENABLE_OFS, gpiof_pkg::PORT3_PIN_LEVELS_OFS, gpiof_pkg::PORT3_OUTPUT_DATA_OFS,
    gpiof_pkg::PORT3_DRIVE_ENABLE_OFS, gpiof_pkg::PORT3_PULLUP_ENABLE_OFS, gpiof_pkg::PORT3_HYSTERESIS_SELECT_OFS,
    gpiof_pkg::PORT3_IRQ_MASK_OFS, gpiof_pkg::PORT3_IRQ_POLARITY_OFS, gpiof_pkg::PORT3_IRQ_PENDING_OFS,
    gpiof_pkg::PORT3_FILTER_SELECT_OFS, gpiof_pkg::PORT3_INPUT_ENABLE_OFS, 16'h5239};
  localparam logic [7:0] RST [13] = '{8'h00, 8'hFF, 8'h1F, 8'h00, 8'h20,
    8'h1F, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h00};
  localparam logic [7:0] FFRD [13] = '{8'h77, 8'hFF, 8'h1F, 8'h1F, 8'h3F,
    8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h00, 8'h77, 8'h1F, 8'h00};
  localparam logic [15:0] FLG = gpiof_pkg::PORT3_IRQ_PENDING_OFS;

  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  p2_pin_in = 8'h00;
  logic [7:0]  p2_level;
  logic [7:0]  port2_input_gate_bits;
  logic [4:0]  p3_pin_in;
  logic [4:0]  p3_pin_out;
  logic [4:0]  p3_pin_oe_n;
  logic [4:0]  port3_pullup_bits;
  logic [4:0]  port3_hysteresis_bits;
  logic        irq;
  logic [4:0]  ext_en = 5'h00;
  int          fails = 0;
  int          num_checks = 0;

  always #2 core_clk = ~core_clk;

  gpiof_top #(.FLT_C1(14'(LIM[1])), .FLT_C2(14'(LIM[2])),
    .FLT_C3(14'(LIM[3])), .FLT_C4(14'(LIM[4])), .FLT_C5(14'(LIM[5])),
    .FLT_C6(14'(LIM[6])), .FLT_C7(14'(LIM[7]))) dut_u (.core_clk(core_clk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .p2_pin_in(p2_pin_in), .p2_level(p2_level),
    .port2_input_gate_bits(port2_input_gate_bits), .p3_pin_in(p3_pin_in),
    .p3_pin_out(p3_pin_out), .p3_pin_oe_n(p3_pin_oe_n),
    .port3_pullup_bits(port3_pullup_bits),
    .port3_hysteresis_bits(port3_hysteresis_bits), .irq(irq));

  gpiof_pins board_u (.core_clk(core_clk), .drv_val(p3_pin_out),
    .drv_oe_n(p3_pin_oe_n), .pull_en(port3_pullup_bits),
    .ext_val(5'h00), .ext_en(ext_en), .pin(p3_pin_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string s);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h expected %h", $time, s, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic w(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : w

  task automatic rc(input logic [15:0] a, input logic [7:0] e,
                    input string s);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, s);
  endtask : rc

  // Hold the masked pins low for n cycles, then let them go
  task automatic pulse(input logic [4:0] m, input int n);
    @(posedge core_clk);
    ext_en <= m;
    repeat (n) @(posedge core_clk);
    ext_en <= 5'h00;
    cyc(24);
  endtask : pulse

  task automatic t_outs(input logic [7:0] oe_n, input logic [7:0] pu);
    chk({3'h0, p3_pin_oe_n}, oe_n, "drive enable pins");
    chk({3'h0, port3_pullup_bits}, pu, "pull-up pins");
    chk({3'h0, port3_hysteresis_bits}, pu, "schmitt pins");
  endtask : t_outs

  task automatic t_regs;
    for (int i = 0; i < 13; i++) rc(AD[i], RST[i], "reset value");
    for (int i = 0; i < 13; i++) w(AD[i], 8'hFF);
    for (int i = 0; i < 13; i++) rc(AD[i], FFRD[i], "all ones");
    cyc(2);
    t_outs(8'h00, 8'h1F);
    chk({3'h0, p3_pin_out}, 8'h1F, "drive value");
    w(gpiof_pkg::PORT3_PULLUP_ENABLE_OFS, 8'h00);
    w(gpiof_pkg::PORT3_HYSTERESIS_SELECT_OFS, 8'h00);
    cyc(2);
    t_outs(8'h00, 8'h00);
    for (int i = 0; i < 13; i++) w(AD[i], RST[i]);
    cyc(24);
    w(FLG, 8'h1F);
    $display("register test done");
  endtask : t_regs

  task automatic t_drive;
    w(gpiof_pkg::PORT3_OUTPUT_DATA_OFS, 8'h05);
    w(gpiof_pkg::PORT3_DRIVE_ENABLE_OFS, 8'h1F);
    cyc(6);
    chk({3'h0, p3_pin_out}, 8'h05, "driven value");
    rc(gpiof_pkg::PORT3_PIN_LEVELS_OFS, 8'h05, "driven levels");
    rc(FLG, 8'h00, "no flag on fall");
    w(gpiof_pkg::PORT3_DRIVE_ENABLE_OFS, 8'h00);
    cyc(6);
    rc(gpiof_pkg::PORT3_PIN_LEVELS_OFS, 8'h1F, "released levels");
    rc(FLG, 8'h1A, "rising flags");
    w(FLG, 8'h1F);
    $display("drive test done");
  endtask : t_drive

  task automatic t_irq;
    w(gpiof_pkg::PORT3_IRQ_MASK_OFS, 8'h01);
    pulse(5'h1F, 6);
    rc(FLG, 8'h1F, "rising edges");
    chk({7'h00, irq}, 8'h01, "irq on");
    w(gpiof_pkg::PORT3_IRQ_MASK_OFS, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h00, "irq masked");
    w(FLG, 8'h00);
    rc(FLG, 8'h1F, "zero write keeps");
    w(FLG, 8'h0A);
    rc(FLG, 8'h15, "one write clears");
    w(gpiof_pkg::PORT3_IRQ_MASK_OFS, 8'h04);
    cyc(2);
    chk({7'h00, irq}, 8'h01, "irq pin2");
    w(FLG, 8'h04);
    cyc(2);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    w(FLG, 8'h1F);
    w(gpiof_pkg::PORT3_IRQ_POLARITY_OFS, 8'h1F);
    pulse(5'h1F, 6);
    rc(FLG, 8'h1F, "falling edges");
    w(FLG, 8'h1F);
    w(gpiof_pkg::PORT3_IRQ_MASK_OFS, 8'h00);
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_gate;
    w(gpiof_pkg::PORT3_IRQ_POLARITY_OFS, 8'h00);
    w(gpiof_pkg::PORT3_INPUT_ENABLE_OFS, 8'h00);
    cyc(6);
    w(FLG, 8'h1F);
    rc(gpiof_pkg::PORT3_PIN_LEVELS_OFS, 8'h00, "gated levels");
    pulse(5'h1F, 6);
    rc(FLG, 8'h00, "gated edges");
    w(gpiof_pkg::PORT3_INPUT_ENABLE_OFS, 8'h1F);
    cyc(6);
    rc(gpiof_pkg::PORT3_PIN_LEVELS_OFS, 8'h1F, "ungated levels");
    w(FLG, 8'h1F);
    $display("input gate test done");
  endtask : t_gate

  task automatic t_filt3;
    w(gpiof_pkg::PORT3_IRQ_POLARITY_OFS, 8'h11);
    for (int c = 1; c <= 7; c++) begin
      w(gpiof_pkg::PORT3_FILTER_SELECT_OFS, 8'(c));
      pulse(5'h01, LIM[c] - 1);
      rc(FLG, 8'h00, "short glitch");
      pulse(5'h01, LIM[c] + 4);
      rc(FLG, 8'h01, "long pulse");
      w(FLG, 8'h1F);
    end
    w(gpiof_pkg::PORT3_FILTER_SELECT_OFS, 8'h10);
    pulse(5'h11, 3);
    rc(FLG, 8'h01, "pin4 filtered");
    w(FLG, 8'h1F);
    w(gpiof_pkg::PORT3_FILTER_SELECT_OFS, 8'h01);
    pulse(5'h11, 3);
    rc(FLG, 8'h10, "pins0-3 filtered");
    w(FLG, 8'h1F);
    w(gpiof_pkg::PORT3_FILTER_SELECT_OFS, 8'h00);
    $display("port 3 filter test done");
  endtask : t_filt3

  task automatic t_p2;
    w(gpiof_pkg::PORT2_FILTER_SELECT_OFS, 8'h71);
    cyc(2);
    @(posedge core_clk);
    p2_pin_in <= 8'hFF;
    cyc(10);
    chk(p2_level, 8'h0F, "low half first");
    cyc(15);
    chk(p2_level, 8'hFF, "high half later");
    w(gpiof_pkg::PORT2_INPUT_ENABLE_OFS, 8'h0F);
    cyc(14);
    chk(port2_input_gate_bits, 8'h0F, "gate pins");
    chk(p2_level, 8'h0F, "gated port 2");
    w(gpiof_pkg::PORT2_INPUT_ENABLE_OFS, 8'hFF);
    w(gpiof_pkg::PORT2_FILTER_SELECT_OFS, 8'h00);
    $display("port 2 test done");
  endtask : t_p2

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    t_outs(8'h1F, 8'h1F);
    chk(port2_input_gate_bits, 8'hFF, "gate reset");
    chk({7'h00, irq}, 8'h00, "irq reset");
    cyc(8);
    t_regs();
    t_drive();
    t_irq();
    t_gate();
    t_filt3();
    t_p2();
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    $display("[ERR] %0t watchdog expired", $time);
    fails++;
    end_sim();
  end
endmodule : tb
